// file: sdbc_pkg.sv
// Purpose: shared constants and types for the block count/size unit
// Assumes: 32-bit Avalon-MM register bus, word addressed by byte offset
// Notes:   offsets are local to this unit
package sdbc_pkg;
  localparam logic [3:0]  SDBC_OFF_BLKCON   = 4'h0;
  localparam logic [3:0]  SDBC_OFF_MODE     = 4'h4;
  localparam logic [3:0]  SDBC_OFF_STATUS   = 4'h8;
  localparam int          SDBC_CNT_LSB      = 16;
  localparam int          SDBC_SIZE_MSB     = 9;
  localparam int          SDBC_MODE_BLOCK_COUNT_ENABLE    = 1;
  localparam logic [15:0] SDBC_CNT_RST      = 16'h0000;
  localparam logic [9:0]  SDBC_SIZE_RST     = 10'h000;
  localparam logic [31:0] SDBC_BAD_READ     = 32'hDEAD_BEEF;
  localparam logic [31:0] SDBC_UNMAPPED     = 32'h0000_0000;

  typedef enum logic [1:0] {
    SDBC_IDLE   = 2'b00,
    SDBC_XFER   = 2'b01,
    SDBC_FINISH = 2'b10
  } sdbc_state_t;
endpackage

// file: sdbc_xfer_if.sv
// Purpose: link between register file and block down-counter
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/100ps
interface sdbc_xfer_if;
  logic        start;
  logic        multi;
  logic        countEnable;
  logic [15:0] loadCount;
  logic        blockDone;
  logic        busy;
  logic        finished;
  logic [15:0] remaining;
  modport ctrl (output start, multi, countEnable, loadCount, blockDone,
                input busy, finished, remaining);
  modport cnt  (input start, multi, countEnable, loadCount, blockDone,
                output busy, finished, remaining);
endinterface

// file: sdbc_counter.sv
// Purpose: per-transfer block down-counter
// Assumes: blockDone pulses once per completed block
// Notes:   single-block or count-disabled transfers end after one block
`timescale 1ns/100ps
module sdbc_counter
  import sdbc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // control link
  sdbc_xfer_if.cnt  xf
);
  typedef struct packed {
    sdbc_state_t state;
    logic [15:0] count;
    logic        useCount;
    logic        finished;
  } sdbc_cnt_t;

  sdbc_cnt_t cur;
  sdbc_cnt_t next_cur;

  always_comb begin
    next_cur          = cur;
    next_cur.finished = 1'b0;
    unique case (cur.state)
      SDBC_IDLE: begin
        if (xf.start) begin
          next_cur.count    = xf.loadCount;
          // count only when enabled and multi
          next_cur.useCount = xf.countEnable & xf.multi;
          next_cur.state    = SDBC_XFER;
          if (xf.countEnable && xf.multi && xf.loadCount == 16'h0000) begin
            next_cur.state = SDBC_FINISH;
          end
        end
      end
      SDBC_XFER: begin
        if (xf.blockDone) begin
          // decrement per block, halt at zero
          if (!cur.useCount || cur.count == 16'h0001) begin
            next_cur.count = cur.useCount ? 16'h0000 : cur.count;
            next_cur.state = SDBC_FINISH;
          end else begin
            next_cur.count = cur.count - 16'h0001;
          end
        end
      end
      SDBC_FINISH: begin
        next_cur.finished = 1'b1;
        next_cur.state    = SDBC_IDLE;
      end
      default: next_cur.state = SDBC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{SDBC_IDLE, 16'h0000, 1'b0, 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign xf.busy      = (cur.state != SDBC_IDLE);
  assign xf.finished  = cur.finished;
  assign xf.remaining = cur.count;

  chk_stop_at_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur.state == SDBC_XFER && cur.useCount && cur.count == 16'h0001 && xf.blockDone)
    |=> ##1 cur.finished) else $error("no finish after last block");
  chk_load_count: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur.state == SDBC_IDLE && xf.start) |=> cur.count == $past(xf.loadCount))
    else $error("counter not loaded at start");
  chk_count_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (cur.state == SDBC_XFER && !cur.useCount && xf.blockDone) |=> cur.state == SDBC_FINISH)
    else $error("uncounted transfer ran past one block");
endmodule

// file: sdbc_block_ctrl.sv
// Purpose: block count and block size control for an SD host controller
// Assumes: Avalon-MM slave, one word per register, start/blockDone from data path
// Notes:   block-control reads during a transfer return a fixed junk pattern
`timescale 1ns/100ps

// What this block does
// - count decrements per finished block; transfer halts at zero
// - count used only with count-enable set and multi-block transfers
// - block size sits in bits 9:0
// - block size is a direct byte count; zero means no data
// - block size governs data phase of block read, write, extended commands
// - during a transfer block-control reads return the fixed junk pattern and block-control writes are dropped
module sdbc_block_ctrl
  import sdbc_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // data path
  input  wire logic        xferStart,
  input  wire logic        xferMulti,
  input  wire logic        blockDone,
  output logic [9:0]       blockBytes,
  output logic             blockCountEnable,
  output logic             xferBusy,
  output logic             xferDone,
  output logic             noData
);
  sdbc_xfer_if xf ();

  typedef struct packed {
    logic [15:0] blocksRemaining;
    logic [9:0]  blockBytes;
    logic [31:0] hostModeControl;
    logic [31:0] readData;
    logic        waitReq;
    logic        noData;
    logic        busy;
    logic        done;
  } sdbc_regs_t;

  sdbc_regs_t cur;
  sdbc_regs_t next_cur;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                       input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) res[i*8 +: 8] = nw[i*8 +: 8];
    end
    return res;
  endfunction

  // address decode shared by the checkers of unmapped accesses
  function automatic logic isMapped(input logic [3:0] a);
    return (a == SDBC_OFF_BLKCON) || (a == SDBC_OFF_MODE) || (a == SDBC_OFF_STATUS);
  endfunction

  logic        access;
  logic [31:0] blkWord;
  logic [31:0] wrBlk;

  always_comb begin
    // taken only while waitrequest is up, so a held request lands once
    access  = (avs_read | avs_write) & cur.waitReq;
    blkWord = {cur.blocksRemaining, 6'h00, cur.blockBytes};
    wrBlk   = merge(blkWord, avs_writedata, avs_byteenable);
  end

  always_comb begin
    next_cur      = cur;
    next_cur.waitReq = ~access;
    next_cur.busy = xf.busy;
    next_cur.done = xf.finished;
    if (access && avs_write) begin
      unique case (avs_address)
        SDBC_OFF_BLKCON: begin
          if (!xf.busy) begin
            next_cur.blocksRemaining = wrBlk[31:SDBC_CNT_LSB];
            next_cur.blockBytes      = wrBlk[SDBC_SIZE_MSB:0];
          end
        end
        SDBC_OFF_MODE: next_cur.hostModeControl = merge(cur.hostModeControl,
                                                         avs_writedata, avs_byteenable);
        default: ;
      endcase
    end
    if (access && avs_read) begin
      unique case (avs_address)
        SDBC_OFF_BLKCON: next_cur.readData = xf.busy ? SDBC_BAD_READ : blkWord;
        SDBC_OFF_MODE:   next_cur.readData = cur.hostModeControl;
        SDBC_OFF_STATUS: next_cur.readData = {16'h0000, xf.remaining[15:1], 1'b0} |
                                             {31'h0, xf.busy};
        default:         next_cur.readData = SDBC_UNMAPPED;
      endcase
    end
    next_cur.noData = ~|next_cur.blockBytes;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '{SDBC_CNT_RST, SDBC_SIZE_RST, 32'h0000_0000, 32'h0000_0000,
               1'b1, 1'b1, 1'b0, 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign xf.start       = xferStart;
  assign xf.multi       = xferMulti;
  assign xf.countEnable = cur.hostModeControl[SDBC_MODE_BLOCK_COUNT_ENABLE];
  assign xf.loadCount   = cur.blocksRemaining;
  assign xf.blockDone   = blockDone;

  sdbc_counter u_counter (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .xf      (xf)
  );

  // waitrequest rests high, so every access costs two cycles but needs no decode
  assign avs_waitrequest  = cur.waitReq;
  assign avs_readdata     = cur.readData;
  // byte count drives the data phase directly
  assign blockBytes       = cur.blockBytes;
  assign noData           = cur.noData;
  assign blockCountEnable = cur.hostModeControl[SDBC_MODE_BLOCK_COUNT_ENABLE];
  assign xferBusy         = cur.busy;
  assign xferDone         = cur.done;

  chk_write_dropped: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_write && avs_address == SDBC_OFF_BLKCON && xf.busy)
    |=> $stable(cur.blockBytes) && $stable(cur.blocksRemaining))
    else $error("block control changed during transfer");

  chk_busy_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_read && avs_address == SDBC_OFF_BLKCON && xf.busy)
    |=> avs_readdata == SDBC_BAD_READ)
    else $error("busy read did not return the junk pattern");

  // fields move only by idle writes
  chk_fields_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(access && avs_write && avs_address == SDBC_OFF_BLKCON && !xf.busy)
    |=> $stable(cur.blockBytes) && $stable(cur.blocksRemaining))
    else $error("block control changed without a write");

  chk_write_taken: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_write && avs_address == SDBC_OFF_BLKCON && avs_byteenable == 4'hF
     && !xf.busy) |=> blockBytes == $past(avs_writedata[9:0]))
    else $error("block size write lost");

  chk_count_taken: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_write && avs_address == SDBC_OFF_BLKCON && avs_byteenable == 4'hF
     && !xf.busy) |=> cur.blocksRemaining == $past(avs_writedata[31:16]))
    else $error("block count write lost");

  chk_idle_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_read && avs_address == SDBC_OFF_BLKCON && !xf.busy)
    |=> avs_readdata[31:16] == cur.blocksRemaining && avs_readdata[15:10] == 6'h00
        && avs_readdata[9:0] == cur.blockBytes)
    else $error("idle read of block control wrong");

  chk_mode_taken: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_write && avs_address == SDBC_OFF_MODE && avs_byteenable == 4'hF)
    |=> blockCountEnable == $past(avs_writedata[SDBC_MODE_BLOCK_COUNT_ENABLE]))
    else $error("count enable write lost");

  chk_no_data: assert property (@(posedge ref_clk) disable iff (!reset_n)
    noData == (blockBytes == 10'h000)) else $error("no-data flag wrong");

  chk_done_pulse: assert property (@(posedge ref_clk) disable iff (!reset_n)
    xferDone |=> !xferDone)
    else $error("completion held for more than one cycle");

  chk_status_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_read && avs_address == SDBC_OFF_STATUS)
    |=> avs_readdata[0] == $past(xf.busy) && avs_readdata[31:16] == 16'h0000)
    else $error("status read wrong");

  chk_ack_timing: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest)
    else $error("read not answered in one cycle");

  chk_wait_single: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for two cycles");

  chk_unmapped_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_read && !isMapped(avs_address)) |=> avs_readdata == SDBC_UNMAPPED)
    else $error("unmapped read not zero");

  chk_unmapped_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (access && avs_write && !isMapped(avs_address))
    |=> $stable(cur.hostModeControl) && $stable(cur.blockBytes))
    else $error("unmapped write changed a register");
endmodule

// file: sdbc_card_model.sv
// Purpose: far-side card model, answers each transfer with block-done pulses
// Assumes: xferBusy from the host marks an open data phase
// Notes:   gap sets the idle cycles between blocks; a large gap keeps the host busy longer
`timescale 1ns/100ps
module sdbc_card_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // transfer link
  input  wire logic       xferBusy,
  input  wire logic [7:0] gap,
  output logic            blockDone
);
  logic [7:0] waitCnt;

  // gap of at least three, so no block lands after the final one
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitCnt   <= 8'h00;
      blockDone <= 1'b0;
    end else begin
      blockDone <= 1'b0;
      if (!xferBusy) begin
        waitCnt <= 8'h00;
      end else if (waitCnt == gap) begin
        waitCnt   <= 8'h00;
        blockDone <= 1'b1;
      end else begin
        waitCnt <= waitCnt + 8'h01;
      end
    end
  end
endmodule

// file: sdbc_block_ctrl_test.sv
// Purpose: self-checking bench for the block count and size unit
// Assumes: one wait state per bus access, card model supplies block-done
// Notes:   byte enables stay all-on; lanes are not exercised
`timescale 1ns/100ps
module sdbc_block_ctrl_test import sdbc_pkg::*;;
  logic        ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic        xferStart, xferMulti, blockDone, blockCountEnable;
  logic        xferBusy, xferDone, noData;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, blkcon;
  logic [9:0]  blockBytes, size;
  logic [7:0]  gap;
  int          errors, comparisons, pulses, base, cnt, bce, multi;
  int          expQ[$];

  sdbc_block_ctrl i_dut (.ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .xferStart,
    .xferMulti, .blockDone, .blockBytes, .blockCountEnable, .xferBusy, .xferDone, .noData);
  sdbc_card_model i_card (.ref_clk, .reset_n, .xferBusy, .gap, .blockDone);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) if (blockDone === 1'b1) pulses <= pulses + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) errors++;
  endtask

  task automatic start(input logic m);
    @(posedge ref_clk);
    xferStart <= 1'b1;
    xferMulti <= m;
    base = pulses;
    @(posedge ref_clk);
    xferStart <= 1'b0;
  endtask

  task automatic waitDone;
    int n;
    n = 0;
    while (xferDone !== 1'b1 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) errors++;
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic end_sim;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: the whole run needs well under a tenth of this
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    end_sim;
  end

  initial begin
    {avs_read, avs_write, xferStart, xferMulti, reset_n} = '0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    gap = 8'h04;
    void'($urandom(32'hA7D35D27));
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    bus(1, 4'hC, 32'hFFFF_FFFF);
    bus(0, SDBC_OFF_BLKCON, 0);
    chk(rd, {SDBC_CNT_RST, 6'h00, SDBC_SIZE_RST});
    bus(0, 4'hC, 0);
    chk(rd, SDBC_UNMAPPED);
    for (int i = 0; i < 3; i++) begin
      cnt = $urandom_range(2, 6);
      size = (i == 0) ? 10'h000 : (i == 1) ? 10'h200 : 10'($urandom_range(1, 1023));
      bce = (i != 1);
      multi = (i != 2);
      gap <= 8'($urandom_range(4, 7));
      blkcon = {16'(cnt), 6'h00, size};
      bus(1, SDBC_OFF_BLKCON, blkcon);
      bus(1, SDBC_OFF_MODE, 32'(bce) << SDBC_MODE_BLOCK_COUNT_ENABLE);
      bus(0, SDBC_OFF_BLKCON, 0);
      chk(rd, blkcon);
      chk(32'(blockBytes), 32'(size));
      chk(32'(noData), 32'(size == 10'h000));
      chk(32'(blockCountEnable), 32'(bce));
      expQ.push_back((bce != 0 && multi != 0) ? cnt : 1);
      start(1'(multi));
      waitDone;
      chk(32'(pulses - base), 32'(expQ.pop_front()));
    end
    // a long block gap keeps the transfer open while software pokes the register
    blkcon = 32'h0002_0155;
    bus(1, SDBC_OFF_BLKCON, blkcon);
    bus(1, SDBC_OFF_MODE, 32'h0000_0002);
    gap <= 8'h3C;
    start(1'b1);
    repeat (2) @(posedge ref_clk);
    chk(32'(xferBusy), 32'h1);
    bus(0, SDBC_OFF_BLKCON, 0);
    chk(rd, SDBC_BAD_READ);
    bus(0, SDBC_OFF_STATUS, 0);
    chk(rd, {16'h0000, blkcon[31:17], 1'b1});
    bus(1, SDBC_OFF_BLKCON, 32'h0005_0077);
    waitDone;
    chk(32'(pulses - base), 32'h2);
    bus(0, SDBC_OFF_BLKCON, 0);
    chk(rd, blkcon);
    bus(0, SDBC_OFF_STATUS, 0);
    chk(rd, 32'h0000_0000);
    end_sim;
  end
endmodule
